// >>> src/wff_top.sv
// Purpose: Wakeup frame pattern filter with APB register access.
// Assumes: Receive bytes and strobes are synchronous to clk.
// Notes:   One filter port reached word by word through an index.
//
// What this block does
// - Detection mode examines frames addressed to MAC
// - Wakeup needs address pass and CRC equal
// - Each filter has own mask and offset
// - Offset is first examinable frame byte
// - Mask bit j selects byte offset plus j
// - Mask words in order, lsb earliest byte
// - Fixed count of reads returns whole set
// - Masks, then command, offset, CRC words
// - Offsets bytewise, CRCs halfwise, low first
// - Four filters take twenty accesses
// - Enable bit suppresses normal reception
// - Match sets seen flag, wakes device
`timescale 1ns/100ps
`default_nettype none
module wff_top #(
  parameter int NF = wff_pkg::WFF_FILTERS
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Receive datapath
  input  wire logic                rxFrameStart,
  input  wire logic                rxByteValid,
  input  wire logic [7:0]          rxByte,
  input  wire logic                rxFrameEnd,
  input  wire logic                rxToMac,
  // Wakeup and power
  output logic                     rxSuppress,
  output logic                     remoteWakeup,
  output logic                     fullPower,
  output logic                     irq
);
  import wff_pkg::*;

  // Port word layout
  localparam int MASK_N   = NF * WFF_MASK_WORDS;
  localparam int CMD_BASE = MASK_N;
  localparam int OFS_BASE = CMD_BASE + NF / WFF_PER_BYTE_WORD;
  localparam int CRC_BASE = OFS_BASE + NF / WFF_PER_BYTE_WORD;
  localparam int NWORDS   = CRC_BASE + NF / WFF_PER_CRC_WORD;
  localparam int IW       = $clog2(NWORDS);

  // Filter storage
  logic [31:0]            maskQ [NF][WFF_MASK_WORDS]; // Byte masks
  logic [WFF_CMD_BITS-1:0] cmdQ [NF];                  // Commands
  logic [7:0]             offQ  [NF];                  // Offsets
  logic [15:0]            crcQ  [NF];                  // Expected CRCs

  // Control state
  logic          enable_q;  // wakeup_detect_enable
  logic          seen_q;    // wakeup_frame_seen
  logic          full_q;    // Fully operational
  logic          wake_q;    // Remote wakeup pulse
  logic [IW-1:0] idx_q;     // Filter port word index
  logic [31:0]   rdata_q;   // Read data
  logic          ready_q;   // Access phase answer
  logic          err_q;     // Unmapped address

  // Bus decode
  logic          access;    // Completing transfer
  logic          wrAcc;
  logic          rdAcc;
  logic          setup;     // Setup cycle
  logic          mapped;
  logic [31:0]   portRd;    // Filter word at index
  logic [31:0]   rdMux;
  logic [WFF_EV_N-1:0] evSet;
  logic [WFF_EV_N-1:0] irqStatus;
  logic [WFF_EV_N-1:0] irqMask;
  logic          irqLine;

  // Receive tracking
  wff_rx_t       rxState_q;
  logic [10:0]   pos_q;     // Byte position in frame
  logic [NF-1:0] hit;       // Per-filter match at frame end
  logic          match;

  assign setup  = psel && !penable;
  assign access = psel && penable && ready_q;
  assign wrAcc  = access && pwrite && !err_q;
  assign rdAcc  = access && !pwrite && !err_q;
  assign mapped = (paddr == WFF_OFS_CTRL)  || (paddr == WFF_OFS_PORT) ||
                  (paddr == WFF_OFS_IRQST) || (paddr == WFF_OFS_IRQMSK) ||
                  (paddr == WFF_OFS_INDEX);

  // Filter word at the current index
  always_comb begin
    portRd = WFF_RST_WORD;
    for (int f = 0; f < NF; f++) begin
      for (int w = 0; w < WFF_MASK_WORDS; w++) begin
        if (int'(idx_q) == f * WFF_MASK_WORDS + w) begin
          portRd = maskQ[f][w];
        end
      end
      if (int'(idx_q) == CMD_BASE + f / WFF_PER_BYTE_WORD) begin
        portRd[(f % WFF_PER_BYTE_WORD) * 8 +: WFF_CMD_BITS] = cmdQ[f];
      end
      if (int'(idx_q) == OFS_BASE + f / WFF_PER_BYTE_WORD) begin
        portRd[(f % WFF_PER_BYTE_WORD) * 8 +: 8] = offQ[f];
      end
      if (int'(idx_q) == CRC_BASE + f / WFF_PER_CRC_WORD) begin
        portRd[(f % WFF_PER_CRC_WORD) * 16 +: 16] = crcQ[f];
      end
    end
  end

  // Register read mux; reserved bits read zero
  always_comb begin
    rdMux = WFF_RST_WORD;
    unique case (paddr)
      WFF_OFS_CTRL: begin
        rdMux[WFF_CTRL_EN_BIT]   = enable_q;
        rdMux[WFF_CTRL_SEEN_BIT] = seen_q;
        rdMux[WFF_CTRL_FULL_BIT] = full_q;
      end
      WFF_OFS_PORT:   rdMux = portRd;
      WFF_OFS_IRQST:  rdMux[WFF_EV_N-1:0] = irqStatus;
      WFF_OFS_IRQMSK: rdMux[WFF_EV_N-1:0] = irqMask;
      WFF_OFS_INDEX:  rdMux[IW-1:0] = idx_q;
      default:        rdMux = WFF_RST_WORD;
    endcase
  end

  // Answer in the first access cycle; data caught at setup
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= WFF_RST_WORD;
    end else if (setup) begin
      ready_q <= 1'b1;
      err_q   <= !mapped;
      rdata_q <= rdMux;
    end else if (access) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end
  end

  // Index steps on every port access, wrapping after the last word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idx_q <= '0;
    end else if ((wrAcc || rdAcc) && paddr == WFF_OFS_PORT) begin
      if (int'(idx_q) == NWORDS - 1) begin
        idx_q <= '0;
      end else begin
        idx_q <= idx_q + IW'(1);
      end
    end
  end

  // Filter storage writes, one word per access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int f = 0; f < NF; f++) begin
        for (int w = 0; w < WFF_MASK_WORDS; w++) begin
          maskQ[f][w] <= WFF_RST_WORD;
        end
        cmdQ[f] <= '0;
        offQ[f] <= '0;
        crcQ[f] <= '0;
      end
    end else if (wrAcc && paddr == WFF_OFS_PORT) begin
      for (int f = 0; f < NF; f++) begin
        for (int w = 0; w < WFF_MASK_WORDS; w++) begin
          if (int'(idx_q) == f * WFF_MASK_WORDS + w) begin
            maskQ[f][w] <= pwdata;
          end
        end
        if (int'(idx_q) == CMD_BASE + f / WFF_PER_BYTE_WORD) begin
          cmdQ[f] <= pwdata[(f % WFF_PER_BYTE_WORD) * 8 +: WFF_CMD_BITS];
        end
        if (int'(idx_q) == OFS_BASE + f / WFF_PER_BYTE_WORD) begin
          offQ[f] <= pwdata[(f % WFF_PER_BYTE_WORD) * 8 +: 8];
        end
        if (int'(idx_q) == CRC_BASE + f / WFF_PER_CRC_WORD) begin
          crcQ[f] <= pwdata[(f % WFF_PER_CRC_WORD) * 16 +: 16];
        end
      end
    end
  end

  // Detection enable; setting it leaves fully operational state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_q <= 1'b0;
    end else if (wrAcc && paddr == WFF_OFS_CTRL) begin
      enable_q <= pwdata[WFF_CTRL_EN_BIT];
    end
  end

  // Seen flag: write one clears, a match in that cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
    end else if (match) begin
      seen_q <= 1'b1;
    end else if (wrAcc && paddr == WFF_OFS_CTRL &&
                 pwdata[WFF_CTRL_SEEN_BIT]) begin
      seen_q <= 1'b0;
    end
  end

  // Power state and remote wakeup pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      full_q <= 1'b1;
      wake_q <= 1'b0;
    end else begin
      wake_q <= match;
      if (match) begin
        full_q <= 1'b1;
      end else if (wrAcc && paddr == WFF_OFS_CTRL &&
                   pwdata[WFF_CTRL_EN_BIT]) begin
        full_q <= 1'b0;
      end
    end
  end

  // Frame tracking: position counts received bytes, saturating
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState_q <= WFF_RX_IDLE;
      pos_q     <= '0;
    end else begin
      unique case (rxState_q)
        WFF_RX_IDLE: begin
          if (rxFrameStart && enable_q) begin
            rxState_q <= WFF_RX_BODY;
            pos_q     <= '0;
          end
        end
        WFF_RX_BODY: begin
          if (rxFrameEnd || !enable_q) begin
            rxState_q <= WFF_RX_IDLE;
          end else if (rxByteValid && pos_q != WFF_POS_MAX) begin
            pos_q <= pos_q + 11'h001;
          end
        end
      endcase
    end
  end

  // One CRC engine per filter, fed by the bytes its mask selects
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : gFlt
      wff_crc_if crcIf ();
      logic [10:0] rel;   // Byte position past the offset
      logic        inWin; // Inside the 128-byte window
      logic        sel;

      assign rel   = pos_q - {3'h0, offQ[g]};
      assign inWin = (pos_q >= {3'h0, offQ[g]}) &&
                     (rel < 11'(WFF_MASK_BITS));
      assign sel   = inWin &&
                     maskQ[g][rel[6:5]][rel[4:0]];
      assign crcIf.clear = rxFrameStart;
      assign crcIf.valid = (rxState_q == WFF_RX_BODY) && rxByteValid &&
                           sel;
      assign crcIf.data  = rxByte;

      wff_crc16 uCrc (
        .clk     (clk),
        .sys_rst (sys_rst),
        .crcIf   (crcIf)
      );

      assign hit[g] = cmdQ[g][WFF_CMD_EN_BIT] &&
                      (crcIf.crc == crcQ[g]);
    end
  endgenerate

  // Address check and CRC compare at the end of a frame
  assign match = (rxState_q == WFF_RX_BODY) && rxFrameEnd &&
                 enable_q && rxToMac && (|hit);

  assign evSet[WFF_EV_MATCH] = match;
  assign evSet[WFF_EV_FRAME] = (rxState_q == WFF_RX_BODY) && rxFrameEnd &&
                               enable_q && rxToMac;

  // Event status, read clears what was shown
  wff_irq #(.N(WFF_EV_N)) uIrq (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .evSet    (evSet),
    .clrEn    (rdAcc && paddr == WFF_OFS_IRQST),
    .clrMask  (rdata_q[WFF_EV_N-1:0]),
    .maskWr   (wrAcc && paddr == WFF_OFS_IRQMSK),
    .maskData (pwdata[WFF_EV_N-1:0]),
    .status   (irqStatus),
    .mask     (irqMask),
    .irq      (irqLine)
  );

  // Outputs, all from flip-flops
  assign prdata       = rdata_q;
  assign pready       = ready_q;
  assign pslverr      = err_q;
  assign rxSuppress   = enable_q;
  assign remoteWakeup = wake_q;
  assign fullPower    = full_q;
  assign irq          = irqLine;
endmodule
`default_nettype wire

// >>> src/wff_pkg.sv
// Purpose: Shared constants and types of the wakeup frame pattern filter.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Filter port word layout is derived from the filter count.
package wff_pkg;
  // Register byte offsets
  localparam logic [11:0] WFF_OFS_CTRL   = 12'h000; // wakeup_control_status
  localparam logic [11:0] WFF_OFS_PORT   = 12'h004; // wakeup_filter_port
  localparam logic [11:0] WFF_OFS_IRQST  = 12'h008; // Event status
  localparam logic [11:0] WFF_OFS_IRQMSK = 12'h00C; // Event mask
  localparam logic [11:0] WFF_OFS_INDEX  = 12'h010; // Port word index
  // Control register fields
  localparam int WFF_CTRL_EN_BIT   = 0; // wakeup_detect_enable
  localparam int WFF_CTRL_SEEN_BIT = 1; // wakeup_frame_seen
  localparam int WFF_CTRL_FULL_BIT = 2; // Fully operational
  // Filter layout
  localparam int WFF_FILTERS    = 4;   // Filters in this variant
  localparam int WFF_MASK_WORDS = 4;   // Mask words per filter
  localparam int WFF_MASK_BITS  = 128; // Bytes covered by one mask
  localparam int WFF_PER_BYTE_WORD = 4; // Command or offset per word
  localparam int WFF_PER_CRC_WORD  = 2; // CRC-16 values per word
  localparam int WFF_CMD_BITS   = 4;   // Stored command bits
  localparam int WFF_CMD_EN_BIT = 0;   // Command bit that enables
  // CRC engine
  localparam logic [15:0] WFF_CRC_POLY = 16'h8005;
  localparam logic [15:0] WFF_CRC_INIT = 16'hFFFF;
  // Event bits
  localparam int WFF_EV_MATCH = 0; // Wakeup frame matched
  localparam int WFF_EV_FRAME = 1; // Addressed frame examined
  localparam int WFF_EV_N     = 2;
  // Reset value and position limit
  localparam logic [31:0] WFF_RST_WORD = 32'h0000_0000;
  localparam logic [10:0] WFF_POS_MAX  = 11'h7FF;
  // Receive tracking state
  typedef enum logic [0:0] {
    WFF_RX_IDLE = 1'b0,
    WFF_RX_BODY = 1'b1
  } wff_rx_t;
endpackage

// >>> src/wff_crc_if.sv
// Purpose: Carrier between the matcher and one CRC-16 engine.
// Assumes: One byte per clock at most.
// Notes:   Engine drives crc, matcher drives the rest.
`timescale 1ns/100ps
`default_nettype none
interface wff_crc_if;
  logic        clear; // Restart at initial value
  logic        valid; // Byte below is selected
  logic [7:0]  data;  // Frame byte
  logic [15:0] crc;   // Running value
  modport engine (input clear, valid, data, output crc);
  modport user   (output clear, valid, data, input crc);
endinterface
`default_nettype wire

// >>> src/wff_crc16.sv
// Purpose: Byte-wide CRC-16 over the bytes a filter selects.
// Assumes: Bits of each byte enter least significant first.
// Notes:   Polynomial and seed are parameters.
`timescale 1ns/100ps
`default_nettype none
module wff_crc16 #(
  parameter logic [15:0] POLY = wff_pkg::WFF_CRC_POLY,
  parameter logic [15:0] SEED = wff_pkg::WFF_CRC_INIT
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Byte stream
  wff_crc_if.engine crcIf
);
  import wff_pkg::*;

  // One byte through the shift register
  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                          input logic [7:0]  d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ POLY;
      end
    end
    return r;
  endfunction

  logic [15:0] crc_q; // Running remainder

  // Clear wins over a byte in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst || crcIf.clear) begin
      crc_q <= SEED;
    end else if (crcIf.valid) begin
      crc_q <= crcByte(crc_q, crcIf.data);
    end
  end

  assign crcIf.crc = crc_q;
endmodule
`default_nettype wire

// >>> src/wff_irq.sv
// Purpose: Sticky event status, mask and one level interrupt.
// Assumes: Clear mask is the value software was shown.
// Notes:   An event in the clearing cycle stays set.
`timescale 1ns/100ps
`default_nettype none
module wff_irq #(
  parameter int N = wff_pkg::WFF_EV_N
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Events and software access
  input  wire logic [N-1:0] evSet,
  input  wire logic         clrEn,
  input  wire logic [N-1:0] clrMask,
  input  wire logic         maskWr,
  input  wire logic [N-1:0] maskData,
  // State
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);
  import wff_pkg::*;

  logic [N-1:0] status_q; // Sticky events
  logic [N-1:0] mask_q;   // Enable per event
  logic         irq_q;    // Registered interrupt

  // Read clears only bits that were shown; set wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~(clrEn ? clrMask : '0)) | evSet;
    end
  end

  // Mask register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= '0;
    end else if (maskWr) begin
      mask_q <= maskData;
    end
  end

  // Level output, one cycle behind status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign status = status_q;
  assign mask   = mask_q;
  assign irq    = irq_q;
endmodule
`default_nettype wire

// >>> bench/wff_top_checker.sv
// Purpose: Port-level assertions for the wakeup frame pattern filter.
// Assumes: Zero-wait APB slave, synchronous active-high reset.
// Notes:   Sees only the top module's ports; attached by bind.
`timescale 1ns/100ps
`default_nettype none
module wff_top_checker
  import wff_pkg::*;
#(
  parameter int NF = WFF_FILTERS
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Receive and wakeup
  input wire logic        rxFrameEnd,
  input wire logic        rxToMac,
  input wire logic        rxSuppress,
  input wire logic        remoteWakeup,
  input wire logic        fullPower
);
  // Port words in one pass of the filter set
  localparam int WORDS = NF * WFF_MASK_WORDS + 2 * NF / WFF_PER_BYTE_WORD
                         + NF / WFF_PER_CRC_WORD;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_wakePulse;
    remoteWakeup |=> !remoteWakeup;
  endproperty
  a_wakePulse: assert property (p_wakePulse)
    else $error("wakeup pulse too long");
  property p_wakeCause;
    remoteWakeup |-> $past(rxFrameEnd && rxToMac);
  endproperty
  a_wakeCause: assert property (p_wakeCause)
    else $error("wakeup without addressed frame end");
  property p_noMac;
    rxFrameEnd && !rxToMac |=> !remoteWakeup;
  endproperty
  a_noMac: assert property (p_noMac)
    else $error("wakeup on frame not for this station");
  property p_fullOnWake;
    remoteWakeup |-> fullPower;
  endproperty
  a_fullOnWake: assert property (p_fullOnWake)
    else $error("wakeup without full power");
  property p_enWr;
    psel && penable && pready && pwrite && paddr == WFF_OFS_CTRL
      && pwdata[WFF_CTRL_EN_BIT] |=> rxSuppress && !fullPower;
  endproperty
  a_enWr: assert property (p_enWr)
    else $error("enable write did not enter detection mode");
  property p_idleNoWake;
    rxFrameEnd && !rxSuppress |=> !remoteWakeup;
  endproperty
  a_idleNoWake: assert property (p_idleNoWake)
    else $error("wakeup while detection off");
  property p_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready not one cycle in first access cycle");
  property p_idx;
    psel && penable && pready && !pwrite && paddr == WFF_OFS_INDEX
      |-> prdata < WORDS;
  endproperty
  a_idx: assert property (p_idx)
    else $error("port index beyond last word");
endmodule
bind wff_top wff_top_checker #(.NF(NF)) chk (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .rxFrameEnd(rxFrameEnd), .rxToMac(rxToMac),
  .rxSuppress(rxSuppress), .remoteWakeup(remoteWakeup),
  .fullPower(fullPower));
`default_nettype wire

// >>> bench/wff_rx_src.sv
// Purpose: Receive datapath model feeding frames to the filter.
// Assumes: One byte per cycle, idle cycle after each frame end.
// Notes:   Stalls and frame ends each invert the byte lines; a frame end after a stall shows the last byte.
`timescale 1ns/100ps
`default_nettype none
module wff_rx_src (
  // Clock
  input  wire logic  clk,
  // Receive stream
  output logic       rxFrameStart,
  output logic       rxByteValid,
  output logic [7:0] rxByte,
  output logic       rxFrameEnd,
  output logic       rxToMac
);
  // Quiet lines at time zero
  initial begin
    rxFrameStart = 1'b0;
    rxByteValid  = 1'b0;
    rxByte       = 8'h00;
    rxFrameEnd   = 1'b0;
    rxToMac      = 1'b0;
  end
  // Payload of byte position p
  function automatic logic [7:0] frameByte(input int p);
    return 8'(p * 17 + 3);
  endfunction
  // One frame; bad flips a byte, slow stalls after odd bytes
  task automatic send(input int len, input logic toMac, input int bad,
                      input logic slow);
    @(posedge clk);
    rxFrameStart <= 1'b1;
    for (int p = 0; p < len; p++) begin
      @(posedge clk);
      rxFrameStart <= 1'b0;
      rxByteValid  <= 1'b1;
      rxByte       <= frameByte(p) ^ ((p == bad) ? 8'h01 : 8'h00);
      if (slow && p[0]) begin
        // Stall: byte lines must not keep a usable value
        @(posedge clk);
        rxByteValid <= 1'b0;
        rxByte      <= ~rxByte;
      end
    end
    @(posedge clk);
    rxByteValid <= 1'b0;
    rxByte      <= ~rxByte;
    rxFrameEnd  <= 1'b1;
    rxToMac     <= toMac;
    @(posedge clk);
    rxFrameEnd <= 1'b0;
    rxToMac    <= ~toMac;
  endtask
endmodule
`default_nettype wire

// >>> bench/wff_top_tb.sv
// Purpose: Self-checking bench for the wakeup frame pattern filter.
// Assumes: Zero-wait APB slave, receive model drives frames.
// Notes:   Filter set rows drive a write and read-back loop.
`timescale 1ns/100ps
`default_nettype none
module wff_top_tb;
  import wff_pkg::*;
  logic        clk, sys_rst, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rxSuppress, remoteWakeup, fullPower, irq;
  logic        rxFrameStart, rxByteValid, rxFrameEnd, rxToMac;
  logic [7:0]  rxByte;
  logic [31:0] wrTab [20]; // Word written
  logic [31:0] expTab [20]; // Word read back
  logic [15:0] crc0;
  int          failures, checks;
  int          badPos [4] = '{34, 3, 0, 4};
  logic        badHit [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  wff_top #(.NF(4)) uut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxFrameStart(rxFrameStart),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxFrameEnd(rxFrameEnd),
    .rxToMac(rxToMac), .rxSuppress(rxSuppress),
    .remoteWakeup(remoteWakeup), .fullPower(fullPower), .irq(irq));
  wff_rx_src src (
    .clk(clk), .rxFrameStart(rxFrameStart), .rxByteValid(rxByteValid),
    .rxByte(rxByte), .rxFrameEnd(rxFrameEnd), .rxToMac(rxToMac));
  // 100 ns clock
  always #50 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; result lands in rd and err
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
    end
    // Answer taken at that same edge, then the request is released
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reference CRC step, bits least significant first
  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? WFF_CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog: far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
  initial begin
    clk = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
    failures = 0; checks = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check(32'({fullPower, rxSuppress, remoteWakeup, irq}), 32'h8);
    $display("test reset done");
    // Filter 0 selects bytes 2, 4 and 34 (offset 2)
    crc0 = crcStep(crcStep(crcStep(WFF_CRC_INIT, src.frameByte(2)),
                   src.frameByte(4)), src.frameByte(34));
    for (int i = 0; i < 16; i++)
      wrTab[i] = {8'(i), 8'hC3, 8'(i * 7), 8'h5A};
    wrTab[0] = 32'h0000_0005;
    wrTab[1] = 32'h0000_0001;
    wrTab[2] = 32'h0000_0000;
    wrTab[3] = 32'h0000_0000;
    wrTab[16] = 32'hF0FE_F0F1;
    wrTab[17] = 32'h7F80_0102;
    wrTab[18] = {16'hBEEF, crc0};
    wrTab[19] = 32'h1234_5678;
    expTab = wrTab;
    expTab[16] = 32'h000E_0001;
    for (int i = 0; i < 20; i++)
      apb(1'b1, WFF_OFS_PORT, wrTab[i]);
    apb(1'b0, WFF_OFS_INDEX, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, WFF_OFS_PORT, 32'h0);
      check(rd, expTab[i]);
      if (i == 4) begin
        apb(1'b0, WFF_OFS_INDEX, 32'h0);
        check(rd, 32'h5);
      end
    end
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    check(32'(err), 32'h1);
    apb(1'b0, WFF_OFS_INDEX, 32'h0);
    check(rd, 32'h0);
    $display("test filter port done");
    // Detection mode with interrupt unmasked
    apb(1'b1, WFF_OFS_IRQMSK, 32'h0000_0001);
    apb(1'b1, WFF_OFS_CTRL, 32'h0000_0001);
    @(negedge clk);
    check(32'({rxSuppress, fullPower}), 32'h2);
    src.send(40, 1'b1, -1, 1'b1);
    @(negedge clk);
    check(32'({remoteWakeup, fullPower}), 32'h3);
    @(negedge clk);
    check(32'({remoteWakeup, irq}), 32'h1);
    apb(1'b0, WFF_OFS_CTRL, 32'h0);
    check(rd & 32'h0000_0007, 32'h0000_0007);
    apb(1'b0, WFF_OFS_IRQST, 32'h0);
    check(rd & 32'h0000_0003, 32'h0000_0003);
    repeat (2) @(negedge clk);
    check(32'(irq), 32'h0);
    $display("test wakeup done");
    // Frame not for this station, then flipped bytes
    apb(1'b1, WFF_OFS_CTRL, 32'h0000_0003);
    src.send(40, 1'b0, -1, 1'b0);
    apb(1'b0, WFF_OFS_CTRL, 32'h0);
    check(32'(rd[WFF_CTRL_SEEN_BIT]), 32'h0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, WFF_OFS_CTRL, 32'h0000_0003);
      src.send(40, 1'b1, badPos[k], 1'b0);
      apb(1'b0, WFF_OFS_CTRL, 32'h0);
      check(32'(rd[WFF_CTRL_SEEN_BIT]), 32'(badHit[k]));
    end
    // Detection off: a good frame is ignored
    apb(1'b1, WFF_OFS_CTRL, 32'h0000_0002);
    src.send(40, 1'b1, -1, 1'b0);
    apb(1'b0, WFF_OFS_CTRL, 32'h0);
    check(rd & 32'h0000_0003, 32'h0);
    check(32'(rxSuppress), 32'h0);
    $display("test frame cases done");
    // Reset in mid-run clears index and filter words
    apb(1'b0, WFF_OFS_PORT, 32'h0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, WFF_OFS_INDEX, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, WFF_OFS_PORT, 32'h0);
    check(rd, 32'h0);
    @(negedge clk);
    check(32'({fullPower, rxSuppress, irq}), 32'h4);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
